// *** pkg/capture_timer_pkg.sv ***
package capture_timer_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_CTRL_A     = 4'h0;
    localparam logic [3:0] IDX_CTRL_B     = 4'h1;
    localparam logic [3:0] IDX_EVENT_CTRL = 4'h4;
    localparam logic [3:0] IDX_IRQ_ENABLE = 4'h5;
    localparam logic [3:0] IDX_FLAGS      = 4'h6;
    localparam logic [3:0] IDX_STATUS     = 4'h7;
    localparam logic [3:0] IDX_DEBUG      = 4'h8;
    localparam logic [3:0] IDX_LATCH      = 4'h9;
    localparam logic [3:0] IDX_CNT_LO     = 4'hA;
    localparam logic [3:0] IDX_CNT_HI     = 4'hB;
    localparam logic [3:0] IDX_CAPTURE_COMPARE_VALUE_LO    = 4'hC;
    localparam logic [3:0] IDX_CAPTURE_COMPARE_VALUE_HI    = 4'hD;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ENABLE_BIT   = 0;
    localparam int MODE_LSB     = 0;
    localparam int EDGE_BIT     = 4;
    localparam int CAPTURE_FLAG_EI_BIT  = 0;
    localparam int WRAP_BIT     = 1;
    localparam int CAPTURE_FLAG_BIT     = 0;
    localparam int RUN_BIT      = 0;
    localparam int DBG_CONT_BIT = 0;

    // ------------------------------------------------------------
    // Counter limits
    // ------------------------------------------------------------
    localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;

    typedef enum logic [2:0] {
        MODE_PERIODIC   = 3'h0,
        MODE_TIMEOUT    = 3'h1,
        MODE_CAPTURE    = 3'h2,
        MODE_FREQ       = 3'h3,
        MODE_WIDTH      = 3'h4,
        MODE_FREQ_WIDTH = 3'h5,
        MODE_SINGLE     = 3'h6,
        MODE_BYTE_PWM   = 3'h7
    } mode_t;

    typedef struct packed {
        logic        enable;
        mode_t       counter_mode_select;
        logic        edge_sel;
        logic        capture_flag_ei;
        logic        wrap_en;
        logic        capture_flag_en;
        logic        wrap_flag;
        logic        capture_flag;
        logic        debug_continue;
        logic [7:0]  latch;
        logic [15:0] counter_value;
        logic [15:0] capture_compare_value;
        logic        running;
        logic [1:0]  fw_phase;
        logic        ev_s1;
        logic        ev_s2;
        logic        ev_prev;
        logic        ack;
        logic [7:0]  rdat;
        logic        wrap_irq;
        logic        capture_flag_irq;
    } state_t;

    localparam state_t RESET_STATE = '0;

endpackage : capture_timer_pkg

// *** design/capture_timer_flags_regs.sv ***
// Behaviour
// - Counter rollover sets wrap flag, except in byte PWM
// - Wrap flag clears only on written one
// - Capture flag clears by one, or by compare low read in capture, frequency, width, combined modes
// - Timer modes flag on counter equals top
// - Frequency mode captures, restarts, sets flag
// - Capture mode copies counter to compare on event
// - Pulse width: restart edge, capture edge
// - Combined mode flags on second active edge, stops
// - Byte PWM flags at duty, period tops
// - Status bit shows running, read only
// - Debug halt freezes unless continue set
// - One shared byte latch for pairs
// - Counter bytes at 0x0A/0x0B, reset zero
// - Software counter write beats count update
// - Compare bytes at 0x0C/0x0D, reset zero
// - Capture takes counter value of moment
// - Full compare value is timer top
// - Byte PWM: low period, high duty
// - Three bit mode field, eight modes
// - Each flag has own interrupt enable
`timescale 1ns/1ps
module capture_timer_flags_regs
    import capture_timer_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        event_i,
    input  wire logic        debug_halt_i,
    output logic             wrap_irq_o,
    output logic             capture_irq_o
);

    // ------------------------------------------------------------
    // State and decode
    // ------------------------------------------------------------
    state_t      st;
    state_t      next_st;
    logic [3:0]  idx;
    logic        req;
    logic        wr_hit;
    logic        rd_hit;
    logic [7:0]  wdat;
    logic        frozen;
    logic        ev_ok;
    logic        act_edge;
    logic        opp_edge;
    logic        run_now;
    logic        tick;
    logic        wrap_set;
    logic        capture_flag_set;
    logic        capture_flag_mode;
    logic [15:0] cnt_inc;
    logic [7:0]  low_inc;

    assign idx    = adr_i[5:2];
    assign req    = cyc_i & stb_i & ~st.ack;
    assign wr_hit = req & we_i & sel_i[0];
    assign rd_hit = req & ~we_i;
    assign wdat   = dat_i[7:0];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.ack = req;
        next_st.ev_s1 = event_i;
        next_st.ev_s2 = st.ev_s1;
        next_st.ev_prev = st.ev_s2;

        frozen = debug_halt_i & ~st.debug_continue;
        ev_ok = st.enable & st.capture_flag_ei & ~frozen;
        act_edge = ev_ok & (st.edge_sel ? (~st.ev_s2 & st.ev_prev)
                                        : (st.ev_s2 & ~st.ev_prev));
        opp_edge = ev_ok & (st.edge_sel ? (st.ev_s2 & ~st.ev_prev)
                                        : (~st.ev_s2 & st.ev_prev));
        case (st.counter_mode_select)
            MODE_TIMEOUT, MODE_FREQ_WIDTH, MODE_SINGLE: begin
                run_now = st.enable & st.running;
            end
            default: begin
                run_now = st.enable;
            end
        endcase
        capture_flag_mode = (st.counter_mode_select == MODE_CAPTURE)
                  | (st.counter_mode_select == MODE_FREQ)
                  | (st.counter_mode_select == MODE_WIDTH)
                  | (st.counter_mode_select == MODE_FREQ_WIDTH);
        tick = run_now & ~frozen;
        cnt_inc = st.counter_value + 16'h0001;
        low_inc = st.counter_value[7:0] + 8'h01;
        wrap_set = 1'b0;
        capture_flag_set = 1'b0;

        if (tick) begin
            next_st.counter_value = cnt_inc;
            wrap_set = (st.counter_value == COUNT_MAX);
        end

        case (st.counter_mode_select)
            MODE_PERIODIC, MODE_TIMEOUT, MODE_SINGLE: begin
                if (tick && st.counter_value == st.capture_compare_value)
                begin
                    capture_flag_set = 1'b1;
                    next_st.counter_value = COUNT_BOTTOM;
                    if (st.counter_mode_select == MODE_SINGLE) begin
                        next_st.running = 1'b0;
                    end
                end
                if (st.counter_mode_select == MODE_TIMEOUT) begin
                    if (act_edge) begin
                        next_st.running = 1'b1;
                    end else if (opp_edge) begin
                        next_st.running = 1'b0;
                    end
                end
                if (st.counter_mode_select == MODE_SINGLE
                    && (act_edge || (st.edge_sel && opp_edge))) begin
                    next_st.running = 1'b1;
                    next_st.counter_value = COUNT_BOTTOM;
                end
            end
            MODE_CAPTURE: begin
                if (act_edge) begin
                    next_st.capture_compare_value = st.counter_value;
                    capture_flag_set = 1'b1;
                end
            end
            MODE_FREQ: begin
                if (act_edge) begin
                    next_st.capture_compare_value = st.counter_value;
                    next_st.counter_value = COUNT_BOTTOM;
                    capture_flag_set = 1'b1;
                end
            end
            MODE_WIDTH: begin
                if (act_edge) begin
                    next_st.counter_value = COUNT_BOTTOM;
                end else if (opp_edge) begin
                    next_st.capture_compare_value = st.counter_value;
                    capture_flag_set = 1'b1;
                end
            end
            MODE_FREQ_WIDTH: begin
                case (st.fw_phase)
                    2'h0: begin
                        if (act_edge) begin
                            next_st.counter_value = COUNT_BOTTOM;
                            next_st.running = 1'b1;
                            next_st.fw_phase = 2'h1;
                        end
                    end
                    2'h1: begin
                        if (opp_edge) begin
                            next_st.capture_compare_value =
                                st.counter_value;
                            next_st.fw_phase = 2'h2;
                        end
                    end
                    2'h2: begin
                        if (act_edge) begin
                            next_st.running = 1'b0;
                            capture_flag_set = 1'b1;
                            next_st.fw_phase = 2'h3;
                        end
                    end
                    default: begin
                        if (!st.capture_flag) begin
                            next_st.fw_phase = 2'h0;
                        end
                    end
                endcase
            end
            default: begin
                wrap_set = 1'b0;
                if (tick) begin
                    next_st.counter_value = {8'h00, low_inc};
                    if (st.counter_value[7:0]
                        == st.capture_compare_value[7:0]) begin
                        next_st.counter_value = COUNT_BOTTOM;
                        wrap_set = 1'b1;
                    end
                    capture_flag_set = (st.counter_value[7:0]
                        == st.capture_compare_value[15:8]);
                end
            end
        endcase

        if (!st.enable) begin
            next_st.running = 1'b0;
            next_st.fw_phase = 2'h0;
        end

        // Bus writes come last so they win over internal updates
        if (wr_hit) begin
            case (idx)
                IDX_CTRL_A: next_st.enable = wdat[ENABLE_BIT];
                IDX_CTRL_B: next_st.counter_mode_select =
                    mode_t'(wdat[MODE_LSB +: 3]);
                IDX_EVENT_CTRL: begin
                    next_st.edge_sel = wdat[EDGE_BIT];
                    next_st.capture_flag_ei = wdat[CAPTURE_FLAG_EI_BIT];
                end
                IDX_IRQ_ENABLE: begin
                    next_st.wrap_en = wdat[WRAP_BIT];
                    next_st.capture_flag_en = wdat[CAPTURE_FLAG_BIT];
                end
                IDX_DEBUG: next_st.debug_continue = wdat[DBG_CONT_BIT];
                IDX_LATCH: next_st.latch = wdat;
                IDX_CNT_LO, IDX_CAPTURE_COMPARE_VALUE_LO: next_st.latch = wdat;
                IDX_CNT_HI: begin
                    next_st.counter_value = {wdat, st.latch};
                end
                IDX_CAPTURE_COMPARE_VALUE_HI: begin
                    next_st.capture_compare_value =
                        {wdat, st.latch};
                end
                default: begin
                    next_st.latch = next_st.latch;
                end
            endcase
        end

        // Read data and read side effects; status has no write path
        next_st.rdat = 8'h00;
        if (rd_hit) begin
            case (idx)
                IDX_CTRL_A: next_st.rdat = {7'h00, st.enable};
                IDX_CTRL_B: next_st.rdat = {5'h00, st.counter_mode_select};
                IDX_EVENT_CTRL: next_st.rdat =
                    {3'h0, st.edge_sel, 3'h0, st.capture_flag_ei};
                IDX_IRQ_ENABLE: next_st.rdat = {6'h00, st.wrap_en, st.capture_flag_en};
                IDX_FLAGS: next_st.rdat =
                    {6'h00, st.wrap_flag, st.capture_flag};
                IDX_STATUS: next_st.rdat = {7'h00, run_now};
                IDX_DEBUG: next_st.rdat = {7'h00, st.debug_continue};
                IDX_LATCH: next_st.rdat = st.latch;
                IDX_CNT_LO: begin
                    next_st.rdat = st.counter_value[7:0];
                    next_st.latch = st.counter_value[15:8];
                end
                IDX_CAPTURE_COMPARE_VALUE_LO: begin
                    next_st.rdat = st.capture_compare_value[7:0];
                    next_st.latch = st.capture_compare_value[15:8];
                end
                IDX_CNT_HI, IDX_CAPTURE_COMPARE_VALUE_HI: next_st.rdat = st.latch;
                default: next_st.rdat = 8'h00;
            endcase
        end

        // Set wins over a clear in the same cycle
        next_st.wrap_flag = (st.wrap_flag
            & ~(wr_hit && idx == IDX_FLAGS && wdat[WRAP_BIT]))
            | wrap_set;
        next_st.capture_flag = (st.capture_flag
            & ~(wr_hit && idx == IDX_FLAGS && wdat[CAPTURE_FLAG_BIT])
            & ~(rd_hit && idx == IDX_CAPTURE_COMPARE_VALUE_LO && capture_flag_mode))
            | capture_flag_set;
        next_st.wrap_irq = next_st.wrap_flag & next_st.wrap_en;
        next_st.capture_flag_irq = next_st.capture_flag & next_st.capture_flag_en;

        if (rst_i) begin
            next_st = RESET_STATE;
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    assign dat_o         = {24'h000000, st.rdat};
    assign ack_o         = st.ack;
    assign wrap_irq_o    = st.wrap_irq;
    assign capture_irq_o = st.capture_flag_irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic cnt_wr;
    logic capture_compare_value_wr;
    assign cnt_wr  = wr_hit && idx == IDX_CNT_HI;
    assign capture_compare_value_wr = wr_hit && idx == IDX_CAPTURE_COMPARE_VALUE_HI;

    sequence fw_open_s;
        st.counter_mode_select == MODE_FREQ_WIDTH && st.fw_phase == 2'h2;
    endsequence
    sequence fw_close_s;
        act_edge && !cnt_wr;
    endsequence

    wrap_rollover_a: assert property (
        tick && st.counter_value == COUNT_MAX
        && st.counter_mode_select != MODE_BYTE_PWM |=> st.wrap_flag)
        else $error("rollover did not set wrap flag");
    wrap_hold_a: assert property (
        st.wrap_flag && !(wr_hit && idx == IDX_FLAGS && wdat[WRAP_BIT])
        |=> st.wrap_flag)
        else $error("wrap flag cleared without a written one");
    capture_flag_read_clear_a: assert property (
        rd_hit && idx == IDX_CAPTURE_COMPARE_VALUE_LO && capture_flag_mode && !capture_flag_set
        |=> !st.capture_flag && st.ack)
        else $error("capture read did not clear capture flag");
    top_match_a: assert property (
        tick && st.counter_value == st.capture_compare_value && !cnt_wr
        && (st.counter_mode_select == MODE_PERIODIC
            || st.counter_mode_select == MODE_TIMEOUT)
        |=> st.capture_flag && st.counter_value == COUNT_BOTTOM)
        else $error("top match missed");
    freq_capture_a: assert property (
        st.counter_mode_select == MODE_FREQ && act_edge
        && !cnt_wr && !capture_compare_value_wr
        |=> st.capture_compare_value == $past(st.counter_value)
            && st.counter_value == COUNT_BOTTOM && st.capture_flag)
        else $error("frequency capture wrong");
    event_capture_a: assert property (
        st.counter_mode_select == MODE_CAPTURE && act_edge && !capture_compare_value_wr
        |=> st.capture_compare_value == $past(st.counter_value)
            && st.capture_flag)
        else $error("event capture wrong");
    width_measure_a: assert property (
        st.counter_mode_select == MODE_WIDTH && opp_edge && !capture_compare_value_wr
        |=> st.capture_compare_value == $past(st.counter_value)
            && st.capture_flag)
        else $error("pulse width capture wrong");
    fw_stop_a: assert property (
        fw_open_s ##0 fw_close_s |=> !st.running && st.capture_flag)
        else $error("combined mode did not stop and flag");
    pwm_duty_a: assert property (
        st.counter_mode_select == MODE_BYTE_PWM && tick
        && st.counter_value[7:0] == st.capture_compare_value[15:8]
        |=> st.capture_flag)
        else $error("duty match missed");
    run_status_a: assert property (
        rd_hit && idx == IDX_STATUS
        |=> st.rdat == {7'h00, $past(run_now)} && st.ack)
        else $error("status bit does not show running");
    debug_freeze_a: assert property (
        frozen && !cnt_wr
        |=> st.counter_value == $past(st.counter_value))
        else $error("counter moved while halted");
    latch_pair_a: assert property (
        rd_hit && idx == IDX_CNT_LO
        |=> st.latch == $past(st.counter_value[15:8]))
        else $error("high byte not latched");
    cnt_write_wins_a: assert property (
        cnt_wr |=> st.counter_value == {$past(wdat), $past(st.latch)})
        else $error("counter write lost");
    irq_and_a: assert property (
        st.capture_flag && st.capture_flag_en |-> capture_irq_o)
        else $error("capture interrupt not raised");
    ack_pulse_a: assert property (
        st.ack |=> !st.ack)
        else $error("ack longer than one cycle");

endmodule : capture_timer_flags_regs

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
module testbench
    import capture_timer_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [5:0] A_CA = 6'h00, A_CB = 6'h04, A_EV = 6'h10;
    localparam logic [5:0] A_IE = 6'h14, A_FL = 6'h18, A_ST = 6'h1C;
    localparam logic [5:0] A_DB = 6'h20, A_LT = 6'h24, A_CNT = 6'h28;
    localparam logic [5:0] A_CCP = 6'h30, A_NONE = 6'h38;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic        we_i = 1'b0, event_i = 1'b0, debug_halt_i = 1'b0;
    logic [5:0]  adr_i = 6'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic        ack_o, wrap_irq_o, capture_irq_o;
    int          n_mismatch = 0, checks = 0, cycles = 0, t;
    logic [15:0] a, b, c, v;
    logic [7:0]  q;

    capture_timer_flags_regs i_capture_timer_flags_regs (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .event_i(event_i),
        .debug_halt_i(debug_halt_i), .wrap_irq_o(wrap_irq_o),
        .capture_irq_o(capture_irq_o));

    always #2 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task print_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // Classic single cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [5:0] ad,
                       input logic [7:0] d, output logic [7:0] r);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= ad;
        sel_i <= 4'hF;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1) n_mismatch++;
        r = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : bus

    task automatic wr(input logic [5:0] ad, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, ad, d, r);
    endtask : wr

    task automatic rd(input logic [5:0] ad, output logic [7:0] r);
        bus(1'b0, ad, 8'h00, r);
    endtask : rd

    task automatic wr16(input logic [5:0] ad, input logic [15:0] d);
        wr(ad, d[7:0]);
        wr(ad + 6'h04, d[15:8]);
    endtask : wr16

    task automatic rd16(input logic [5:0] ad, output logic [15:0] r);
        rd(ad, r[7:0]);
        rd(ad + 6'h04, r[15:8]);
    endtask : rd16

    task automatic chk(input string s, input logic [15:0] e,
                       input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    task automatic chk_in(input string s, input logic [15:0] lo,
                          input logic [15:0] hi, input logic [15:0] g);
        checks++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            n_mismatch++;
            $display("mismatch %s expected %h..%h seen %h", s, lo, hi, g);
        end
    endtask : chk_in

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wt

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        t = $urandom(27637);
        wt(12);
        rst_i <= 1'b0;
        wt(1);
        rd(A_FL, q);   chk("flags", 16'h0, q);
        rd(A_ST, q);   chk("status", 16'h0, q);
        rd(A_DB, q);   chk("debug", 16'h0, q);
        rd16(A_CNT, v); chk("cnt", 16'h0, v);
        rd16(A_CCP, v); chk("capture_compare_value", 16'h0, v);
        v = 16'($urandom());
        wr(A_LT, v[7:0]);
        rd(A_LT, q);   chk("latch", v[7:0], q);
        wr(A_NONE, 8'hFF);
        rd(A_NONE, q); chk("unmapped", 16'h0, q);
        for (int m = 0; m < 8; m++) begin
            wr(A_CB, 8'(m));
            rd(A_CB, q); chk("mode", 16'(m), q);
        end
        v = 16'($urandom());
        wr16(A_CCP, v);
        rd(A_CCP, q);  chk("capture_compare_value lo", v[7:0], q);
        rd(A_LT, q);   chk("latch hi", v[15:8], q);
        // Periodic: capture flag at top, counter bounded by top
        t = 20 + $urandom_range(40);
        wr16(A_CCP, 16'(t));
        wr(A_CB, 8'h00);
        wr(A_IE, 8'h01);
        wr(A_CA, 8'h01);
        wt(t + 8);
        rd16(A_CNT, v); chk_in("cnt top", 16'h0, 16'(t), v);
        rd(A_FL, q);   chk("capture_flag set", 16'h01, q);
        chk("capture_flag irq", 16'h1, capture_irq_o);
        wr(A_CA, 8'h00);
        wr(A_FL, 8'h00);
        rd(A_FL, q);   chk("capture_flag kept", 16'h01, q);
        wr(A_FL, 8'h01);
        rd(A_FL, q);   chk("capture_flag clr", 16'h00, q);
        chk("capture_flag irq clr", 16'h0, capture_irq_o);
        // Wrap from 0xFFF0 in capture mode with no events
        wr(A_CB, 8'h02);
        wr16(A_CNT, 16'hFFF0);
        wr(A_IE, 8'h02);
        wr(A_CA, 8'h01);
        rd(A_ST, q);   chk("run", 16'h01, q);
        wr(A_ST, 8'h00);
        rd(A_ST, q);   chk("run ro", 16'h01, q);
        wt(30);
        rd(A_FL, q);   chk("wrap set", 16'h02, q);
        chk("wrap irq", 16'h1, wrap_irq_o);
        // Counter write while counting wins over the count
        v = 16'h1000 + 16'($urandom_range(16'h7000));
        wr16(A_CNT, v);
        rd16(A_CNT, a); chk_in("cnt wr", v, v + 16'h0C, a);
        debug_halt_i <= 1'b1;
        wt(2);
        rd(A_CNT, a[7:0]);
        rd(A_CNT, b[7:0]);
        chk("frozen", a[7:0], b[7:0]);
        wr(A_DB, 8'h01);
        rd(A_CNT, a[7:0]);
        rd(A_CNT, b[7:0]);
        q = b[7:0] - a[7:0];
        chk_in("dbg run", 16'h0001, 16'h0008, 16'(q));
        debug_halt_i <= 1'b0;
        wr(A_CA, 8'h00);
        rd(A_ST, q);   chk("stopped", 16'h00, q);
        wr(A_FL, 8'h00);
        rd(A_FL, q);   chk("wrap kept", 16'h02, q);
        wr(A_FL, 8'h02);
        rd(A_FL, q);   chk("wrap clr", 16'h00, q);
        chk("wrap irq clr", 16'h0, wrap_irq_o);
        // Capture on rising event, read clears the flag
        wr16(A_CNT, 16'h0000);
        wr(A_EV, 8'h01);
        wr(A_CA, 8'h01);
        wt($urandom_range(50));
        rd16(A_CNT, a);
        event_i <= 1'b1;
        wt(6);
        rd16(A_CNT, b);
        rd(A_FL, q);   chk("capture_flag ev", 16'h01, q);
        rd16(A_CCP, c); chk_in("capture_flag val", a, b, c);
        rd(A_FL, q);   chk("capture_flag rd clr", 16'h00, q);
        event_i <= 1'b0;
        // Frequency: capture then restart from zero
        wr(A_CB, 8'h03);
        wt(80);
        rd16(A_CNT, a);
        event_i <= 1'b1;
        wt(6);
        rd16(A_CCP, c); chk_in("frq cap", a, a + 16'h20, c);
        rd16(A_CNT, b); chk_in("frq rst", 16'h0, 16'h20, b);
        event_i <= 1'b0;
        wr(A_CA, 8'h00);
        wr(A_FL, 8'h03);
        // Byte PWM: low byte period, high byte duty
        t = 30 + $urandom_range(30);
        v = {8'(t - 10), 8'(t)};
        wr(A_CB, 8'h07);
        wr16(A_CCP, v);
        wr16(A_CNT, 16'h0000);
        wr(A_CA, 8'h01);
        wt(3 * t);
        rd(A_FL, q);   chk("pwm flags", 16'h03, q);
        repeat (8) begin
            rd16(A_CNT, a);
            chk_in("pwm cnt", 16'h0, 16'(t), a);
        end
        // Pulse width: rising edge restarts, falling edge captures
        wr(A_CA, 8'h00);
        wr(A_FL, 8'h03);
        wr(A_CB, 8'h04);
        wr(A_CA, 8'h01);
        t = 10 + $urandom_range(40);
        event_i <= 1'b1;
        wt(t);
        event_i <= 1'b0;
        wt(8);
        rd(A_FL, q);   chk("pw flag", 16'h01, q);
        rd16(A_CCP, c); chk("pw width", 16'(t - 1), c);
        rd(A_FL, q);   chk("pw rd clr", 16'h00, q);
        // Single shot: start on event, stop and flag at top
        wr(A_CA, 8'h00);
        wr(A_CB, 8'h06);
        wr16(A_CCP, 16'h0020);
        wr(A_CA, 8'h01);
        rd(A_ST, q);   chk("ss idle", 16'h00, q);
        event_i <= 1'b1;
        wt(8);
        rd(A_ST, q);   chk("ss run", 16'h01, q);
        wt(60);
        rd(A_ST, q);   chk("ss stop", 16'h00, q);
        rd(A_FL, q);   chk("ss flag", 16'h01, q);
        wr(A_FL, 8'h01);
        // Combined: start, capture width, stop on second rising edge
        event_i <= 1'b0;
        wr(A_CA, 8'h00);
        wr(A_CB, 8'h05);
        wr(A_CA, 8'h01);
        event_i <= 1'b1;
        wt(20);
        event_i <= 1'b0;
        wt(20);
        event_i <= 1'b1;
        wt(8);
        rd(A_ST, q);   chk("fw stop", 16'h00, q);
        rd(A_FL, q);   chk("fw flag", 16'h01, q);
        rd16(A_CCP, c); chk("fw width", 16'h0013, c);
        // Time-out check: rising edge starts, falling edge stops
        event_i <= 1'b0;
        wr(A_CA, 8'h00);
        wr(A_CB, 8'h01);
        wr(A_CA, 8'h01);
        event_i <= 1'b1;
        wt(6);
        rd(A_ST, q);   chk("to run", 16'h01, q);
        event_i <= 1'b0;
        wt(6);
        rd(A_ST, q);   chk("to stop", 16'h00, q);
        print_verdict();
    end
endmodule : testbench
